// >>> verilog/bsc_pkg.sv
// package: register map, fields, modes and timing of the bridge converter control block
package bsc_pkg;
  // register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0c;
  // mode register fields
  localparam int OP_MODE_LSB = 0;
  localparam int PORT_DRIVE_ENABLE_BIT = 4;
  localparam int PORT_A_BIT = 5;
  localparam int PORT_B_BIT = 6;
  // status register fields
  localparam int READY_BIT = 0;
  localparam int SETTLED_BIT = 1;
  localparam int POWERDOWN_BIT = 2;
  localparam int BUSY_BIT = 3;
  localparam int HELD_BIT = 4;
  // control register fields
  localparam int SINGLE_SHOT_BIT = 0;
  localparam int CAL_BIT = 1;
  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // timing
  localparam int SETTLE_CYCLES = 64;
  localparam int RESTART_LATENCY = 3;
  typedef enum logic [2:0] {
    MODE_CONT = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_STANDBY = 3'b011,
    MODE_CAL_ZERO = 3'b100,
    MODE_CAL_FULL = 3'b101,
    MODE_RSV6 = 3'b110,
    MODE_RSV7 = 3'b111
  } bsc_mode_e;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : bsc_pkg

// >>> verilog/bsc_ctrl.sv
// control of restart, single-shot, reset and standby for a sigma-delta bridge converter
`timescale 1ns/1ps
module bsc_ctrl #(
  parameter int SETTLE = bsc_pkg::SETTLE_CYCLES,
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control pins
  input wire logic restart_n,
  input wire logic standby_n,
  // conversion engine
  input wire logic [DATA_W-1:0] sampleData,
  output logic modClear,
  output logic sampleEn,
  output logic mclkOut,
  output logic ready_n,
  output logic portPinA,
  output logic portPinB,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = $clog2(SETTLE + 1);

  initial begin
    if (SETTLE < 2 || DATA_W < 1 || DATA_W > 32) begin
      $error("bsc_ctrl: unsupported parameter values");
    end
  end

  // synchronisers for the asynchronous pins
  logic [1:0] rstSync_q;
  logic [1:0] stbSync_q;
  logic restartPrev_q;
  logic restartLow;
  logic restartRise;
  logic restartFall;
  logic pinStandby;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h3;
      stbSync_q <= 2'h3;
      restartPrev_q <= 1'b1;
    end else begin
      rstSync_q <= {rstSync_q[0], restart_n};
      stbSync_q <= {stbSync_q[0], standby_n};
      restartPrev_q <= rstSync_q[1];
    end
  end

  assign restartLow = !rstSync_q[1];
  assign restartFall = restartPrev_q && !rstSync_q[1];
  assign restartRise = !restartPrev_q && rstSync_q[1];
  assign pinStandby = !stbSync_q[1];

  // registers
  logic [31:0] mode_q;
  logic [31:0] ctrl_q;
  logic [DATA_W-1:0] data_q;
  logic ready_q;
  logic settled_q;
  logic busy_q;
  logic [CW-1:0] settleCnt_q;
  logic modeStandby;
  logic standby;
  logic settleDone;
  logic startConv;
  logic wrMode;
  logic wrCtrl;
  logic [2:0] opMode;

  assign opMode = mode_q[bsc_pkg::OP_MODE_LSB +: 3];
  assign modeStandby = (opMode == bsc_pkg::MODE_STANDBY);
  assign standby = pinStandby || modeStandby;

  // write channel: address and data taken in either order
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q;
  assign wrMode = doWrite && (awAddr_q == bsc_pkg::MODE_OFS);
  assign wrCtrl = doWrite && (awAddr_q == bsc_pkg::CTRL_OFS);

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic logic mapped(input logic [7:0] a);
    return a == bsc_pkg::MODE_OFS || a == bsc_pkg::STATUS_OFS || a == bsc_pkg::DATA_OFS || a == bsc_pkg::CTRL_OFS;
  endfunction : mapped

  // registers return to defaults only through reset; access still served while restart is held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_q) ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // restart does not touch the configuration
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= bsc_pkg::MODE_RST;
      ctrl_q <= bsc_pkg::CTRL_RST;
    end else begin
      if (wrMode) begin
        mode_q <= mergeBytes(mode_q, wData_q, wStrb_q);
      end else if (busy_q && settleDone && !modClear && opMode == bsc_pkg::MODE_SINGLE) begin
        mode_q[bsc_pkg::OP_MODE_LSB +: 3] <= bsc_pkg::MODE_IDLE;
      end
      if (wrCtrl) begin
        ctrl_q <= mergeBytes(ctrl_q, wData_q, wStrb_q);
      end
    end
  end

  // read channel
  logic [31:0] statusWord;
  assign statusWord = 32'(ready_q) << bsc_pkg::READY_BIT | 32'(settled_q) << bsc_pkg::SETTLED_BIT
    | 32'(standby) << bsc_pkg::POWERDOWN_BIT | 32'(busy_q) << bsc_pkg::BUSY_BIT
    | 32'(restartLow) << bsc_pkg::HELD_BIT;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        bsc_pkg::MODE_OFS: s_axi_rdata <= mode_q;
        bsc_pkg::STATUS_OFS: s_axi_rdata <= statusWord;
        bsc_pkg::DATA_OFS: s_axi_rdata <= 32'(data_q);
        bsc_pkg::CTRL_OFS: s_axi_rdata <= ctrl_q;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // conversion sequencing
  logic singleRestart;
  logic calStart;
  logic convMode;
  assign singleRestart = ctrl_q[bsc_pkg::SINGLE_SHOT_BIT];
  assign calStart = wrCtrl && wData_q[bsc_pkg::CAL_BIT] && wStrb_q[0];
  assign convMode = (opMode == bsc_pkg::MODE_CONT) || (opMode == bsc_pkg::MODE_SINGLE)
    || (opMode == bsc_pkg::MODE_CAL_ZERO) || (opMode == bsc_pkg::MODE_CAL_FULL);
  assign startConv = (wrMode && wStrb_q[0] && wData_q[bsc_pkg::OP_MODE_LSB +: 3] == bsc_pkg::MODE_SINGLE)
    || (restartRise && singleRestart) || calStart;
  assign settleDone = (settleCnt_q == CW'(SETTLE - 1));

  // filter settle counter: cleared while restart low, one count per clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_q <= '0;
      busy_q <= 1'b1;
    end else if (restartLow || restartFall || standby) begin
      settleCnt_q <= '0;
      busy_q <= !standby && !singleRestart;
    end else if (startConv || restartRise) begin
      settleCnt_q <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (settleDone) begin
        settleCnt_q <= '0;
        busy_q <= (opMode == bsc_pkg::MODE_CONT);
      end else begin
        settleCnt_q <= settleCnt_q + CW'(1);
      end
    end else if (convMode && opMode == bsc_pkg::MODE_CONT && !singleRestart) begin
      busy_q <= 1'b1;
    end
  end

  // ready and settled are active low indications
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
      settled_q <= 1'b1;
      data_q <= '0;
    end else if (standby) begin
      ready_q <= 1'b1;
      settled_q <= 1'b1;
    end else if (busy_q && settleDone && !restartLow && !restartFall) begin
      ready_q <= 1'b0;
      settled_q <= 1'b0;
      data_q <= sampleData;
    end else if (doWrite && awAddr_q == bsc_pkg::DATA_OFS) begin
      ready_q <= ready_q;
    end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == bsc_pkg::DATA_OFS) begin
      ready_q <= 1'b1;
    end
  end

  // outputs; master clock stays free under reset and standby
  assign mclkOut = clock;
  assign modClear = restartLow || restartFall || standby;
  assign sampleEn = busy_q && !modClear;
  assign ready_n = ready_q;
  assign portPinA = mode_q[bsc_pkg::PORT_DRIVE_ENABLE_BIT] && mode_q[bsc_pkg::PORT_A_BIT];
  assign portPinB = mode_q[bsc_pkg::PORT_DRIVE_ENABLE_BIT] && mode_q[bsc_pkg::PORT_B_BIT];

  // assertions
  // named steps of the restart and conversion sequences
  sequence s_rise;
    restartRise && !standby;
  endsequence
  sequence s_done;
    busy_q && settleDone && !modClear;
  endsequence
  sequence s_shot_pin;
    restartRise && singleRestart && !standby;
  endsequence
  sequence s_shot_mode;
    wrMode && wStrb_q[0] && wData_q[bsc_pkg::OP_MODE_LSB +: 3] == bsc_pkg::MODE_SINGLE && !modClear;
  endsequence

  // restart pin: hold, clear, keep configuration
  a_held_clear: assert property (@(posedge clock) disable iff (!rst_n)
    restartLow |-> modClear && !sampleEn) else $error("restart low but sampling");
  a_fall_clears: assert property (@(posedge clock) disable iff (!rst_n)
    restartFall |=> settleCnt_q == '0) else $error("restart fall did not clear filter");
  a_keep_config: assert property (@(posedge clock) disable iff (!rst_n)
    restartFall && !wrMode |=> $stable(mode_q)) else $error("restart changed configuration");
  a_keep_ctrl: assert property (@(posedge clock) disable iff (!rst_n)
    restartFall && !wrCtrl |=> $stable(ctrl_q)) else $error("restart changed control register");
  a_clear_count: assert property (@(posedge clock) disable iff (!rst_n)
    modClear |=> settleCnt_q == '0) else $error("filter counted while cleared");

  // the pin reaches the logic after exactly two flops, alike on every device of the clock
  a_fall_sync: assert property (@(posedge clock) disable iff (!rst_n)
    restartFall |-> !$past(restart_n, 2)) else $error("restart fall seen at wrong edge");
  a_rise_sync: assert property (@(posedge clock) disable iff (!rst_n)
    restartRise |-> $past(restart_n, 2)) else $error("restart rise seen at wrong edge");

  // sampling resumes one edge after the release
  a_rise_sample: assert property (@(posedge clock) disable iff (!rst_n)
    s_rise ##1 !restartLow |-> busy_q || startConv) else $error("no sampling after restart");
  a_release_run: assert property (@(posedge clock) disable iff (!rst_n)
    s_rise ##1 !modClear |-> sampleEn) else $error("sampling not enabled after release");
  a_sample_gate: assert property (@(posedge clock) disable iff (!rst_n)
    sampleEn |-> busy_q && !restartLow && !standby) else $error("sampling while held");

  // conversions: started by pin, mode or calibration, finished with fresh data
  a_shot_start: assert property (@(posedge clock) disable iff (!rst_n)
    s_shot_pin |=> busy_q && settleCnt_q == '0) else $error("restart rise did not start conversion");
  a_mode_shot: assert property (@(posedge clock) disable iff (!rst_n)
    s_shot_mode
    |=> busy_q && settleCnt_q == '0 && opMode == bsc_pkg::MODE_SINGLE) else $error("single mode did not start");
  a_single_idle: assert property (@(posedge clock) disable iff (!rst_n)
    busy_q && settleDone && opMode == bsc_pkg::MODE_SINGLE && !wrMode && !standby && !modClear
    |=> opMode == bsc_pkg::MODE_IDLE && !ready_n) else $error("single shot did not finish");
  a_result_ready: assert property (@(posedge clock) disable iff (!rst_n)
    s_done |=> !ready_n && !settled_q && data_q == $past(sampleData)) else $error("result not delivered");
  a_cal_start: assert property (@(posedge clock) disable iff (!rst_n)
    calStart && !modClear |=> busy_q && settleCnt_q == '0) else $error("calibration did not start");

  // ready only falls through a finished conversion
  a_ready_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    ready_n && !busy_q |=> ready_n) else $error("ready fell without conversion");

  // reset behaviour, watched without the reset disable
  a_reset_ready: assert property (@(posedge clock)
    !rst_n |-> ready_n && !s_axi_bvalid && !s_axi_rvalid) else $error("ready or bus active in reset");
  a_reset_defaults: assert property (@(posedge clock)
    !rst_n |-> mode_q == bsc_pkg::MODE_RST && ctrl_q == bsc_pkg::CTRL_RST
    && settleCnt_q == '0 && !portPinA && !portPinB) else $error("registers not at defaults in reset");

  // standby keeps data, configuration and the interface, forces ready and settled high and busy low
  a_standby_ready: assert property (@(posedge clock) disable iff (!rst_n)
    standby |=> ready_n && settled_q) else $error("standby did not force ready high");
  a_standby_idle: assert property (@(posedge clock) disable iff (!rst_n)
    standby |=> !busy_q) else $error("converting in standby");
  a_standby_data: assert property (@(posedge clock) disable iff (!rst_n)
    standby |=> $stable(data_q)) else $error("data changed in standby");
  a_standby_keep: assert property (@(posedge clock) disable iff (!rst_n)
    standby && !wrMode && !wrCtrl && !busy_q
    |=> $stable(mode_q) && $stable(ctrl_q)) else $error("configuration changed in standby");
  a_pd_flag: assert property (@(posedge clock) disable iff (!rst_n)
    modeStandby |-> statusWord[bsc_pkg::POWERDOWN_BIT]) else $error("powerdown flag wrong");
  a_pd_pin: assert property (@(posedge clock) disable iff (!rst_n)
    pinStandby |-> modClear && statusWord[bsc_pkg::POWERDOWN_BIT]) else $error("standby pin not obeyed");

  // register bus keeps answering in every state
  a_write_block: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
  a_write_hold: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_hold: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response dropped");

  // port pins
  a_ports_off: assert property (@(posedge clock) disable iff (!rst_n)
    !mode_q[bsc_pkg::PORT_DRIVE_ENABLE_BIT] |-> !portPinA && !portPinB) else $error("ports driven");
  a_ports_follow: assert property (@(posedge clock) disable iff (!rst_n)
    mode_q[bsc_pkg::PORT_DRIVE_ENABLE_BIT] |-> portPinA == mode_q[bsc_pkg::PORT_A_BIT]
    && portPinB == mode_q[bsc_pkg::PORT_B_BIT]) else $error("ports not following");
endmodule : bsc_ctrl

// >>> testbench/bsc_host_pins.sv
// host-side model of the restart and standby pins
`timescale 1ns/1ps
module bsc_host_pins (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // requests from the bench
  input wire logic holdRestart,
  input wire logic holdStandby,
  // pins toward the device
  output logic restart_n,
  output logic standby_n
);
  // pins move just after the edge, so every device on the shared clock sees them alike
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      restart_n <= 1'b1;
      standby_n <= 1'b1;
    end else begin
      restart_n <= ~holdRestart;
      standby_n <= ~holdStandby;
    end
  end
endmodule : bsc_host_pins

// >>> testbench/bsc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module bsc_ctrl_tb;
  localparam int SET = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic holdRestart = 1'b0;
  logic holdStandby = 1'b0;
  logic restart_n, standby_n, modClear, sampleEn, mclkOut, ready_n, portPinA, portPinB;
  logic [23:0] sampleData = 24'h5a3c96;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int bad_count = 0;
  int compares = 0;
  always #4 clock = ~clock;
  bsc_host_pins host (.clock(clock), .rst_n(rst_n), .holdRestart(holdRestart), .holdStandby(holdStandby),
    .restart_n(restart_n), .standby_n(standby_n));
  bsc_ctrl #(.SETTLE(SET), .DATA_W(24)) DUT (.clock(clock), .rst_n(rst_n), .restart_n(restart_n),
    .standby_n(standby_n), .sampleData(sampleData), .modClear(modClear), .sampleEn(sampleEn),
    .mclkOut(mclkOut), .ready_n(ready_n), .portPinA(portPinA), .portPinB(portPinB),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // handshakes are judged at the falling edge; inputs only move at rising edges
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic aDone, wDone, aHit, wHit;
    aDone = 1'b0;
    wDone = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(negedge clock);
      aHit = awvalid && awready;
      wHit = wvalid && wready;
      @(posedge clock);
      if (aHit) begin
        awvalid <= 1'b0;
        aDone = 1'b1;
      end
      if (wHit) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do @(negedge clock); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clock);
    bready <= 1'b0;
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock); while (arready !== 1'b1);
    @(posedge clock);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(negedge clock);
    rd = rdata;
    resp = rresp;
    @(posedge clock);
    rready <= 1'b0;
  endtask : axiRd
  task automatic waitRdy(input logic want);
    int n;
    n = 0;
    while (ready_n !== want && n < 400) begin
      @(negedge clock);
      n++;
    end
    chk("ready_n wait", want, ready_n);
  endtask : waitRdy
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1 chk("mclkOut high", 1, mclkOut);
      @(negedge clock);
      chk("mclkOut low", 0, mclkOut);
      chk("ready_n in reset", 1, ready_n);
    end
    @(posedge clock);
    rst_n <= 1'b1;
    axiRd(bsc_pkg::MODE_OFS);
    chk("mode default", bsc_pkg::MODE_RST, rd);
    axiRd(bsc_pkg::CTRL_OFS);
    chk("ctrl default", bsc_pkg::CTRL_RST, rd);
    waitRdy(1'b0);
  endtask : t_reset
  task automatic t_ports();
    for (int i = 0; i < 4; i++) begin
      axiWr(bsc_pkg::MODE_OFS, 32'h11 | (32'(i) << bsc_pkg::PORT_A_BIT));
      chk("portPinA", 32'(i & 1), portPinA);
      chk("portPinB", 32'(i >> 1), portPinB);
    end
    axiWr(bsc_pkg::MODE_OFS, 32'h61);
    chk("pins disabled", 0, {portPinA, portPinB});
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(negedge clock);
    chk("ready_n mid reset", 1, ready_n);
    chk("pins mid reset", 0, {portPinA, portPinB});
    @(posedge clock);
    rst_n <= 1'b1;
    axiRd(bsc_pkg::MODE_OFS);
    chk("mode after reset", bsc_pkg::MODE_RST, rd);
    axiWr(bsc_pkg::MODE_OFS, 32'h0);
    waitRdy(1'b0);
  endtask : t_ports
  task automatic t_restart();
    @(posedge clock);
    holdRestart <= 1'b1;
    repeat (6) @(negedge clock);
    chk("modClear held", 1, modClear);
    chk("sampleEn held", 0, sampleEn);
    axiRd(bsc_pkg::DATA_OFS);
    repeat (3 * SET) @(negedge clock);
    chk("no result while held", 1, ready_n);
    axiRd(bsc_pkg::MODE_OFS);
    chk("config kept", 32'h0, rd);
    @(posedge clock);
    holdRestart <= 1'b0;
    repeat (6) @(negedge clock);
    chk("modClear released", 0, modClear);
    chk("sampleEn released", 1, sampleEn);
    waitRdy(1'b0);
  endtask : t_restart
  task automatic t_single();
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_IDLE));
    repeat (3 * SET) @(negedge clock);
    axiRd(bsc_pkg::DATA_OFS);
    chk("ready_n idle", 1, ready_n);
    @(posedge clock);
    sampleData <= 24'h0f1e2d;
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_SINGLE));
    waitRdy(1'b0);
    axiRd(bsc_pkg::MODE_OFS);
    chk("back to idle", 32'(bsc_pkg::MODE_IDLE), rd & 32'h7);
    axiRd(bsc_pkg::DATA_OFS);
    chk("single data", 32'h000f_1e2d, rd);
    repeat (3 * SET) @(negedge clock);
    chk("one conversion only", 1, ready_n);
  endtask : t_single
  task automatic t_shot();
    axiWr(bsc_pkg::CTRL_OFS, 32'h1 << bsc_pkg::SINGLE_SHOT_BIT);
    @(posedge clock);
    holdRestart <= 1'b1;
    repeat (3 * SET) @(negedge clock);
    chk("ready_n before start", 1, ready_n);
    @(posedge clock);
    holdRestart <= 1'b0;
    waitRdy(1'b0);
    axiRd(bsc_pkg::DATA_OFS);
    chk("shot data", {8'h00, sampleData}, rd);
    repeat (3 * SET) @(negedge clock);
    chk("one shot only", 1, ready_n);
    axiWr(bsc_pkg::CTRL_OFS, 32'h1 << bsc_pkg::CAL_BIT);
    waitRdy(1'b0);
    axiRd(bsc_pkg::DATA_OFS);
  endtask : t_shot
  task automatic t_standby();
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_CONT));
    waitRdy(1'b0);
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_IDLE));
    repeat (3 * SET) @(negedge clock);
    @(posedge clock);
    holdStandby <= 1'b1;
    repeat (6) @(negedge clock);
    chk("ready_n standby", 1, ready_n);
    axiRd(bsc_pkg::STATUS_OFS);
    chk("powerdown set", 1, rd[bsc_pkg::POWERDOWN_BIT]);
    chk("settled high", 1, rd[bsc_pkg::SETTLED_BIT]);
    axiRd(bsc_pkg::DATA_OFS);
    chk("data kept", {8'h00, sampleData}, rd);
    @(posedge clock);
    holdStandby <= 1'b0;
    repeat (6) @(negedge clock);
    axiRd(bsc_pkg::STATUS_OFS);
    chk("powerdown clear", 0, rd[bsc_pkg::POWERDOWN_BIT]);
    axiRd(bsc_pkg::MODE_OFS);
    chk("mode resumed", 32'(bsc_pkg::MODE_IDLE), rd & 32'h7);
    repeat (3 * SET) @(negedge clock);
    chk("ready stays high", 1, ready_n);
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_SINGLE));
    waitRdy(1'b0);
    axiWr(bsc_pkg::MODE_OFS, 32'(bsc_pkg::MODE_STANDBY));
    axiRd(bsc_pkg::STATUS_OFS);
    chk("mode powerdown", 1, rd[bsc_pkg::POWERDOWN_BIT]);
    chk("ready_n mode standby", 1, ready_n);
  endtask : t_standby
  task automatic t_bad();
    axiRd(8'h10);
    chk("unmapped rresp", bsc_pkg::RESP_SLVERR, resp);
    chk("unmapped rdata", 0, rd);
    axiWr(8'h14, 32'h1);
    chk("unmapped bresp", bsc_pkg::RESP_SLVERR, resp);
  endtask : t_bad
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    t_reset();
    t_ports();
    t_restart();
    t_single();
    t_shot();
    t_standby();
    t_bad();
    end_sim();
  end
  // whole run needs a few hundred cycles; this span is far beyond it
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end
endmodule : bsc_ctrl_tb
